// *** apms_pkg.sv ***
/*
 * Shared constants and types for the amplifier power-mode sequencer.
 * Assumes a single 100 MHz control clock and an 8-bit register port.
 */
package apms_pkg;

    // Channel enable and shutdown control register
    localparam logic [7:0] CTRL_ADDR    = 8'h01;
    localparam int         LEFT_EN_BIT  = 7;
    localparam int         RIGHT_EN_BIT = 6;
    localparam int         SOFT_SD_BIT  = 5;
    localparam logic [7:0] CTRL_RST     = 8'hc0;  // Both speakers on, active mode
    localparam logic [7:0] CTRL_WMASK   = 8'he0;  // Only the three control bits store
    localparam logic [7:0] RDATA_NONE   = 8'h00;

    // Timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int NS_PER_MS       = 1000000;
    localparam int STARTUP_TIME_MS = 5;
    localparam int TIMER_W         = 20;

    // Gain code
    localparam int              GAIN_W    = 5;
    localparam logic [GAIN_W-1:0] GAIN_RST  = 5'h00;
    localparam logic [GAIN_W-1:0] GAIN_MIN  = 5'h00;
    localparam logic [GAIN_W-1:0] GAIN_MAX  = 5'h1f;
    localparam logic [GAIN_W-1:0] GAIN_STEP = 5'h01;

    // Power sequence states
    typedef enum logic [1:0] {
        ST_DOWN,
        ST_WARMUP,
        ST_RUN
    } apms_state_t;

endpackage

// *** apms_interval_timer.sv ***
/*
 * Down-counting interval timer: load a count, done once it reaches zero.
 * Assumes clear and load are synchronous to ref_clk; clear wins over load.
 */
module apms_interval_timer
    import apms_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic               clear,
    input  wire logic               load,
    input  wire logic [TIMER_W-1:0] load_val,
    output logic                    done
);

    logic [TIMER_W-1:0] count_q;

    // Count down to zero and stop there
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (clear) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= load_val;
        end else if (count_q != '0) begin
            count_q <= count_q - TIMER_W'(1);
        end
    end

    assign done = (count_q == '0);

endmodule

// *** apms_edge_det.sv ***
/*
 * Rise and fall detector for a group of internal levels.
 * Assumes the input is already synchronous to ref_clk.
 */
module apms_edge_det #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] sig,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    logic [W-1:0] prev_q;

    // Previous value, starts at the level's own reset value
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= RST_VAL;
        end else begin
            prev_q <= sig;
        end
    end

    // One-cycle pulses on change
    assign rise = sig & ~prev_q;
    assign fall = ~sig & prev_q;

endmodule

// *** apms_sequencer.sv ***
/*
 * Power-mode, shutdown and start-up gain sequencer of a stereo amplifier.
 * Holds the channel enable / shutdown control register, times the output
 * stage enable after the shutdown pin rises, and steers the start-up and
 * ramped gain. Assumes the serial bus front end delivers one-cycle register
 * strobes, and that the gain-control detector supplies a noise gate level
 * and up/down requests, all synchronous to ref_clk.
 */
// Notes on behaviour
// - Pin high powers register port and control
// - Leaving pin shutdown starts with soft shutdown clear
// - Output stage enabled five ms after pin
// - Hardware start loads default fixed gain immediately
// - After hardware start, loop waits for gate
// - Soft shutdown release loads latest fixed gain
// - Fixed gain changes ramp at attack/release rate
// - Both speakers off, active: gain held fixed
// - Speaker enable rising restarts at fixed gain
// - Register defaults allow playback without configuration
// - Speaker enables off only disable speaker drivers
// - Soft shutdown bit disables the amplifier
// - Pin low powers down, restores register defaults
// - No loop-requested gain change while below noise gate
// - Decreases spaced by attack, increases by release
module apms_sequencer
    import apms_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS)
) (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic               shutdown_pin_n,
    input  wire logic               reg_wr_en,
    input  wire logic               reg_rd_en,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    output logic      [7:0]         reg_rdata,
    input  wire logic [GAIN_W-1:0]  fixed_gain,
    input  wire logic               agc_enable,
    input  wire logic               above_gate,
    input  wire logic               loop_up_req,
    input  wire logic               loop_down_req,
    input  wire logic [TIMER_W-1:0] attack_cycles,
    input  wire logic [TIMER_W-1:0] release_cycles,
    output logic                    ctrl_powered,
    output logic                    output_stage_en,
    output logic                    left_speaker_on,
    output logic                    right_speaker_on,
    output logic      [GAIN_W-1:0]  gain_out
);

    apms_state_t        state_q;
    logic [7:0]         ctrl_q;
    logic [7:0]         rdata_q;
    logic [GAIN_W-1:0]  gain_q;
    logic [GAIN_W-1:0]  fixed_q;
    logic               soft_shutdown;
    logic               left_channel_enable;
    logic               right_channel_enable;
    logic               pin_start;
    logic               warm_done;
    logic               att_done;
    logic               rel_done;
    logic               sws_fall;
    logic [1:0]         spk_rise;
    logic               restart;
    logic               both_off;
    logic               play;
    logic               want_track;
    logic               track_up;
    logic               track_step;
    logic               step_up;
    logic               step_down;
    logic               gain_change;
    logic               force_fixed;

    // Control register fields
    assign soft_shutdown        = ctrl_q[SOFT_SD_BIT];
    assign left_channel_enable  = ctrl_q[LEFT_EN_BIT];
    assign right_channel_enable = ctrl_q[RIGHT_EN_BIT];

    // Pin seen high while still powered down
    assign pin_start = (state_q == ST_DOWN) && shutdown_pin_n;

    // Power sequence: down, warm-up delay, running
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_DOWN;
        end else if (!shutdown_pin_n) begin
            state_q <= ST_DOWN;
        end else begin
            unique case (state_q)
                ST_DOWN: begin
                    state_q <= ST_WARMUP;
                end
                ST_WARMUP: begin
                    if (warm_done) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // Output stage enable delay, restarted by a low pin
    apms_interval_timer u_startup_timer (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .clear    (!shutdown_pin_n),
        .load     (pin_start),
        .load_val (TIMER_W'(STARTUP_CYCLES - 1)),
        .done     (warm_done)
    );

    // Control register; writable only while the port is powered
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
        end else if (!shutdown_pin_n) begin
            ctrl_q <= CTRL_RST;
        end else if (reg_wr_en && (reg_addr == CTRL_ADDR) && (state_q != ST_DOWN)) begin
            ctrl_q <= reg_wdata & CTRL_WMASK;
        end
    end

    // Registered read data, zero for other addresses
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= RDATA_NONE;
        end else if (reg_rd_en) begin
            if ((reg_addr == CTRL_ADDR) && (state_q != ST_DOWN)) begin
                rdata_q <= ctrl_q;
            end else begin
                rdata_q <= RDATA_NONE;
            end
        end
    end

    assign reg_rdata = rdata_q;

    // Transitions that restart at fixed gain
    apms_edge_det #(
        .W       (1),
        .RST_VAL (1'b0)
    ) u_sws_edge (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .sig     (soft_shutdown),
        .rise    (),
        .fall    (sws_fall)
    );

    apms_edge_det #(
        .W       (2),
        .RST_VAL (2'b11)
    ) u_spk_edge (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .sig     ({left_channel_enable, right_channel_enable}),
        .rise    (spk_rise),
        .fall    ()
    );

    // Host keeps each sequence whole, so a restart never meets a new shutdown
    assign restart  = pin_start || sws_fall || (|spk_rise);
    assign both_off = !left_channel_enable && !right_channel_enable;
    assign play     = (state_q == ST_RUN) && !soft_shutdown;

    // Drive enables; all other control stays up with speakers off
    assign ctrl_powered     = (state_q != ST_DOWN);
    assign output_stage_en  = play;
    assign left_speaker_on  = play && left_channel_enable;
    assign right_speaker_on = play && right_channel_enable;

    // Gain step decisions, each direction paced by its own timer
    assign want_track  = (fixed_q != fixed_gain);
    assign track_up    = (fixed_gain > fixed_q);
    assign force_fixed = (state_q == ST_DOWN) || restart || (both_off && !soft_shutdown) || !agc_enable;

    always_comb begin
        track_step = 1'b0;
        step_up    = 1'b0;
        step_down  = 1'b0;
        if (play && !force_fixed) begin
            if (want_track) begin
                track_step = track_up ? rel_done : att_done;
                step_up    = track_up && rel_done;
                step_down  = !track_up && att_done;
            end else if (above_gate) begin
                step_down = loop_down_req && att_done;
                step_up   = !loop_down_req && loop_up_req && rel_done;
            end
        end
    end

    assign gain_change = step_up || step_down;

    // Amplifier gain and the fixed gain it currently tracks
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gain_q  <= GAIN_RST;
            fixed_q <= GAIN_RST;
        end else if (force_fixed) begin
            gain_q  <= fixed_gain;
            fixed_q <= fixed_gain;
        end else begin
            if (step_up && (gain_q != GAIN_MAX)) begin
                gain_q <= gain_q + GAIN_STEP;
            end else if (step_down && (gain_q != GAIN_MIN)) begin
                gain_q <= gain_q - GAIN_STEP;
            end
            if (track_step) begin
                fixed_q <= track_up ? (fixed_q + GAIN_STEP) : (fixed_q - GAIN_STEP);
            end
        end
    end

    assign gain_out = gain_q;

    // Attack and release spacing, both restarted by every gain change
    apms_interval_timer u_attack_timer (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .clear    (force_fixed),
        .load     (gain_change),
        .load_val (attack_cycles),
        .done     (att_done)
    );

    apms_interval_timer u_release_timer (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .clear    (force_fixed),
        .load     (gain_change),
        .load_val (release_cycles),
        .done     (rel_done)
    );

    // Helper counters for the checks below
    logic [TIMER_W-1:0] warm_cnt_q;
    logic [TIMER_W-1:0] gap_q;
    logic               gapv_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            warm_cnt_q <= '0;
        end else if (state_q == ST_WARMUP) begin
            warm_cnt_q <= warm_cnt_q + TIMER_W'(1);
        end else begin
            warm_cnt_q <= '0;
        end
    end

    // Cycles since the last paced gain change
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q  <= '0;
            gapv_q <= 1'b0;
        end else if (force_fixed) begin
            gap_q  <= '0;
            gapv_q <= 1'b0;
        end else if (gain_change) begin
            gap_q  <= '0;
            gapv_q <= 1'b1;
        end else if (gap_q != '1) begin
            gap_q  <= gap_q + TIMER_W'(1);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    ctrl_power_up_a: assert property (pin_start |=> ctrl_powered && (state_q == ST_WARMUP))
        else $error("control not powered after pin rise");
    sws_default_a: assert property ($rose(state_q == ST_WARMUP) |-> !soft_shutdown)
        else $error("soft shutdown set after pin release");
    stage_delay_a: assert property ($rose(output_stage_en) && $past(state_q == ST_WARMUP)
        |-> warm_cnt_q == TIMER_W'(STARTUP_CYCLES))
        else $error("output stage delay wrong");
    hw_gain_a: assert property (pin_start |=> gain_q == $past(fixed_gain))
        else $error("hardware start gain not fixed gain");
    sws_gain_a: assert property (sws_fall |=> gain_q == $past(fixed_gain))
        else $error("soft start gain not latest fixed gain");
    spk_gain_a: assert property ((|spk_rise) || (both_off && !soft_shutdown)
        |=> gain_q == $past(fixed_gain))
        else $error("speaker start gain not fixed gain");
    spk_only_a: assert property (play && !left_channel_enable
        |-> !left_speaker_on && output_stage_en && ctrl_powered)
        else $error("speaker disable affected other circuits");
    sws_off_a: assert property ($rose(soft_shutdown) |-> !output_stage_en ##1 !left_speaker_on[*2])
        else $error("soft shutdown left amplifier running");
    pin_reset_a: assert property (!shutdown_pin_n |=> (ctrl_q == CTRL_RST) && !ctrl_powered)
        else $error("pin low did not restore defaults");
    gate_hold_a: assert property (play && !force_fixed && !want_track && !above_gate
        |=> $stable(gain_q))
        else $error("gain changed below noise gate");
    attack_gap_a: assert property (step_down && gapv_q && !force_fixed |-> gap_q >= attack_cycles)
        else $error("gain decreases too close");
    release_gap_a: assert property (step_up && gapv_q && !force_fixed |-> gap_q >= release_cycles)
        else $error("gain increases too close");

    reach_run_c: cover property (pin_start ##[1:1000] $rose(output_stage_en));
    soft_restart_c: cover property (soft_shutdown ##1 sws_fall);
    ramp_step_c: cover property (track_step ##[1:100] track_step);
    loop_down_c: cover property (step_down && !want_track);

endmodule

// *** apms_host_model.sv ***
/*
 * Host model: drives the shutdown pin and the register strobes.
 * Assumes strobes are taken on the rising edge of ref_clk.
 */
module apms_host_model (
    input  wire logic       ref_clk,
    output logic            shutdown_pin_n,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus at time zero, pin high
    initial begin
        shutdown_pin_n = 1'b1;
        reg_wr_en      = 1'b0;
        reg_rd_en      = 1'b0;
        reg_addr       = 8'h00;
        reg_wdata      = 8'h00;
    end

    // One strobe cycle, then idle lines show inverted values
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_wr_en = wr;
        reg_rd_en = ~wr;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    // Data is settled one cycle after the read strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        xfer(1'b0, a, 8'h00);
        d = reg_rdata;
    endtask

    // Pin moves only between whole sequences unless a test means otherwise
    task automatic pin(input logic v);
        @(posedge ref_clk);
        #1;
        shutdown_pin_n = v;
    endtask
endmodule

// *** apms_sequencer_bench.sv ***
/*
 * Self-checking bench for the power-mode sequencer.
 * Assumes the host model drives the pin and the register port.
 */
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module apms_sequencer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import apms_pkg::*;
    localparam int N = 20;

    logic                ref_clk = 1'b0;
    logic                rst_n;
    logic                shutdown_pin_n;
    logic                reg_wr_en;
    logic                reg_rd_en;
    logic [7:0]          reg_addr;
    logic [7:0]          reg_wdata;
    logic [7:0]          reg_rdata;
    logic [7:0]          rd;
    logic [GAIN_W-1:0]   fixed_gain;
    logic [GAIN_W-1:0]   gain_out;
    logic [TIMER_W-1:0]  attack_cycles;
    logic [TIMER_W-1:0]  release_cycles;
    logic                agc_enable;
    logic                above_gate;
    logic                loop_up_req;
    logic                loop_down_req;
    logic                ctrl_powered;
    logic                output_stage_en;
    logic                left_speaker_on;
    logic                right_speaker_on;
    int                  miscompares = 0;
    int                  comparisons = 0;
    int                  cnt;

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    apms_host_model apms_host_model_inst (
        .ref_clk(ref_clk), .shutdown_pin_n(shutdown_pin_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
    );

    apms_sequencer #(.STARTUP_CYCLES(N)) apms_sequencer_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .shutdown_pin_n(shutdown_pin_n),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fixed_gain(fixed_gain),
        .agc_enable(agc_enable), .above_gate(above_gate), .loop_up_req(loop_up_req),
        .loop_down_req(loop_down_req), .attack_cycles(attack_cycles),
        .release_cycles(release_cycles), .ctrl_powered(ctrl_powered),
        .output_stage_en(output_stage_en), .left_speaker_on(left_speaker_on),
        .right_speaker_on(right_speaker_on), .gain_out(gain_out)
    );

    task automatic give_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Count edges until the output stage comes up, bounded
    task automatic wait_oe;
        cnt = 0;
        while (output_stage_en !== 1'b1) begin
            cyc(1);
            cnt++;
            if (cnt > 4 * N) begin
                miscompares++;
                give_verdict();
            end
        end
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] ex);
        apms_host_model_inst.rd(a, rd);
        `CHK(nm, ex, rd)
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        agc_enable = 1'b1;
        above_gate = 1'b0;
        loop_up_req = 1'b0;
        loop_down_req = 1'b0;
        fixed_gain = 5'h06;
        attack_cycles = 20'h00003;
        release_cycles = 20'h00004;
        repeat (16) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        wait_oe();
        `CHK("startup", N + 1, cnt)
        `CHK("powered", 1'b1, ctrl_powered)
        `CHK("hw_gain", 5'h06, gain_out)
        `CHK("spk_dflt", 2'b11, {left_speaker_on, right_speaker_on})
        rdchk("ctrl_dflt", 8'h01, 8'hc0);
        // Soft shutdown, new fixed gain, release
        apms_host_model_inst.wr(8'h01, 8'h20);
        `CHK("sd_outs", 3'b000, {output_stage_en, left_speaker_on, right_speaker_on})
        fixed_gain = 5'h0c;
        cyc(3);
        `CHK("sd_hold", 5'h06, gain_out)
        apms_host_model_inst.wr(8'h01, 8'hc0);
        `CHK("sd_off_oe", 1'b1, output_stage_en)
        cyc(2);
        `CHK("sd_gain", 5'h0c, gain_out)
        // Ramped fixed gain change while playing
        fixed_gain = 5'h0f;
        cyc(2);
        `CHK("ramp_slow", 1'b1, gain_out < 5'h0f)
        cyc(30);
        `CHK("ramp_end", 5'h0f, gain_out)
        // Loop requests gated by the noise gate, then spaced
        loop_up_req = 1'b1;
        cyc(20);
        `CHK("gate_hold", 5'h0f, gain_out)
        above_gate = 1'b1;
        cyc(1);
        `CHK("gate_open", 5'h10, gain_out)
        cyc(2);
        `CHK("up_space", 5'h10, gain_out)
        loop_up_req = 1'b0;
        loop_down_req = 1'b1;
        cyc(6);
        `CHK("down_step", 1'b1, gain_out < 5'h10)
        loop_down_req = 1'b0;
        above_gate = 1'b0;
        // Loop off: gain follows the fixed gain at once
        agc_enable = 1'b0;
        fixed_gain = 5'h12;
        cyc(1);
        `CHK("agc_off_gain", 5'h12, gain_out)
        agc_enable = 1'b1;
        // Speaker enables
        fixed_gain = 5'h08;
        apms_host_model_inst.wr(8'h01, 8'h00);
        cyc(2);
        `CHK("spk_off", 3'b100, {output_stage_en, left_speaker_on, right_speaker_on})
        `CHK("spk_off_gain", 5'h08, gain_out)
        apms_host_model_inst.wr(8'h01, 8'h80);
        cyc(2);
        `CHK("spk_left", 2'b10, {left_speaker_on, right_speaker_on})
        `CHK("spk_gain", 5'h08, gain_out)
        // Unmapped address and unstored bits
        apms_host_model_inst.wr(8'h02, 8'h00);
        rdchk("unmapped_wr", 8'h01, 8'h80);
        rdchk("unmapped_rd", 8'h02, 8'h00);
        apms_host_model_inst.wr(8'h01, 8'hff);
        rdchk("ctrl_mask", 8'h01, 8'he0);
        // Pin shutdown, then an interrupted warm-up
        apms_host_model_inst.pin(1'b0);
        cyc(1);
        `CHK("pin_down", 2'b00, {ctrl_powered, output_stage_en})
        apms_host_model_inst.pin(1'b1);
        cyc(N / 2);
        apms_host_model_inst.pin(1'b0);
        apms_host_model_inst.pin(1'b1);
        wait_oe();
        `CHK("restart", N + 1, cnt)
        rdchk("ctrl_restore", 8'h01, 8'hc0);
        give_verdict();
    end
endmodule
